// [common/nvm_pkg.sv]
// Purpose: shared constants and types for the memory self-access controller and its core end
// Assumes: one clock, each clock edge is one instruction cycle
// Notes: register indices are the block's own choice; no bus, the core end drives them
//
// What this block and its software do
// - 55h, AAh, then write-go starts writes
// - Software masks interrupts across unlock code
// - Refuse writes unless write-allow is set
// - Hardware clears write-allow only on reset or warm reset
// - Clearing write-allow never aborts running write
// - Write-go needs write-allow set earlier
// - Write end clears write-go, sets complete flag
// - Flash read fetched over next two cycles
// - Flash read data valid after two fillers
// - Data registers hold until read or write
// - Flash write needs permit and unprotected word
// - Software loads address, data, space, then go
// - Flash write stalls core two instruction slots
// - Software puts no-ops in stalled slots
// - Software may read back and compare
// - Space select picks data or flash
// - Go bits set-only; hardware clears them
// - Pin or watchdog reset flags write abort
// - Data read ready next instruction cycle
package nvm_pkg;
	localparam logic [2:0] reg_control = 3'h0;
	localparam logic [2:0] reg_unlock = 3'h1;
	localparam logic [2:0] reg_data_low = 3'h2;
	localparam logic [2:0] reg_data_high = 3'h3;
	localparam logic [2:0] reg_addr_low = 3'h4;
	localparam logic [2:0] reg_addr_high = 3'h5;
	localparam logic [2:0] reg_flag = 3'h6;
	localparam int bit_read_go = 0;
	localparam int bit_write_go = 1;
	localparam int bit_write_allow = 2;
	localparam int bit_write_abort = 3;
	localparam int bit_space = 7;
	localparam logic [7:0] unlock_first = 8'h55;
	localparam logic [7:0] unlock_second = 8'haa;
	localparam logic [7:0] control_reset = 8'h00;
	localparam logic [7:0] high_data_mask = 8'h3f;
	localparam logic [7:0] high_addr_mask = 8'h07;
	localparam int clk_mhz = 10;
	// Data EEPROM write time in microseconds
	localparam int ee_write_us = 4;
	localparam logic [15:0] ee_write_cycles = 16'(ee_write_us * clk_mhz);
	localparam logic [1:0] flash_stall_slots = 2'h2;
	localparam logic [1:0] flash_read_slots = 2'h2;
	typedef enum logic [1:0] {st_idle, st_ee_write, st_flash_write, st_flash_read} nvm_state_t;
	typedef enum logic [1:0] {unl_none, unl_first, unl_armed} unlock_state_t;
endpackage

// [common/nvm_if.sv]
// Purpose: special-register access from the core to the memory controller
// Assumes: one write or read per cycle, result registered and seen by the core one cycle later
// Notes: stall tells the core to discard the instruction in that slot
interface nvm_if (
	input wire logic clk
);
	logic wr_en;
	logic rd_en;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic stall;
	logic write_complete_flag;
	modport device (input wr_en, rd_en, addr, wdata, output rdata, stall, write_complete_flag);
	modport core (output wr_en, rd_en, addr, wdata, input rdata, stall, write_complete_flag);
endinterface

// [src/nvm_ctrl.sv]
// Purpose: data EEPROM and flash self access through special registers
// Assumes: each clk edge is one instruction cycle; memories are flip-flop arrays here
// Notes: pin and watchdog resets arrive as a one-cycle warm_reset pulse, not rst_b
module nvm_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic warm_reset,
	// Configuration
	input wire logic flash_write_permit,
	input wire logic code_protect_partial,
	input wire logic [10:0] protect_limit,
	// Core side
	nvm_if.device bus
);
	logic [7:0] ee_mem [64];
	logic [13:0] fl_mem [2048];
	logic [7:0] mem_data_low, mem_data_high, mem_addr_low, mem_addr_high;
	logic space_select, write_allow, write_go, read_go, write_abort_flag, wcf;
	logic [15:0] count;
	logic [7:0] rdata;
	logic stall;
	nvm_pkg::nvm_state_t state;
	nvm_pkg::unlock_state_t unl;
	logic [7:0] next_data_low, next_data_high, next_addr_low, next_addr_high, next_rdata;
	logic next_space, next_allow, next_write_go, next_read_go, next_abort, next_wcf, next_stall;
	logic [15:0] next_count;
	nvm_pkg::nvm_state_t next_state;
	nvm_pkg::unlock_state_t next_unl;
	logic ee_commit, fl_commit;
	logic [10:0] fl_addr;
	logic ctl_wr, busy, fl_ok;

	assign fl_addr = {mem_addr_high[2:0], mem_addr_low};
	assign ctl_wr = bus.wr_en && bus.addr == nvm_pkg::reg_control;
	assign busy = state != nvm_pkg::st_idle;
	assign fl_ok = flash_write_permit && !(code_protect_partial && fl_addr >= protect_limit);

	always_comb begin
		next_data_low = mem_data_low;
		next_data_high = mem_data_high;
		next_addr_low = mem_addr_low;
		next_addr_high = mem_addr_high;
		next_space = space_select;
		next_allow = write_allow;
		next_write_go = write_go;
		next_read_go = read_go;
		next_abort = write_abort_flag;
		next_wcf = wcf;
		next_count = count;
		next_state = state;
		next_unl = unl;
		next_stall = 1'b0;
		ee_commit = 1'b0;
		fl_commit = 1'b0;
		// tracker reset on any other write
		if (bus.wr_en) begin
			if (bus.addr == nvm_pkg::reg_unlock) begin
				if (bus.wdata == nvm_pkg::unlock_first)
					next_unl = nvm_pkg::unl_first;
				else if (bus.wdata == nvm_pkg::unlock_second && unl == nvm_pkg::unl_first)
					next_unl = nvm_pkg::unl_armed;
				else
					next_unl = nvm_pkg::unl_none;
			end else begin
				next_unl = nvm_pkg::unl_none;
			end
		end
		if (bus.wr_en && !busy) begin
			if (bus.addr == nvm_pkg::reg_data_low)
				next_data_low = bus.wdata;
			else if (bus.addr == nvm_pkg::reg_data_high)
				next_data_high = bus.wdata & nvm_pkg::high_data_mask;
			else if (bus.addr == nvm_pkg::reg_addr_low)
				next_addr_low = bus.wdata;
			else if (bus.addr == nvm_pkg::reg_addr_high)
				next_addr_high = bus.wdata & nvm_pkg::high_addr_mask;
		end
		if (ctl_wr) begin
			next_allow = bus.wdata[nvm_pkg::bit_write_allow];
			// Software may clear a stale abort flag
			if (!bus.wdata[nvm_pkg::bit_write_abort])
				next_abort = 1'b0;
			if (!busy)
				next_space = bus.wdata[nvm_pkg::bit_space];
		end
		// Software clears the complete flag by writing zero to it
		if (bus.wr_en && bus.addr == nvm_pkg::reg_flag && !bus.wdata[0])
			next_wcf = 1'b0;
		case (state)
			nvm_pkg::st_idle: begin
				if (ctl_wr && bus.wdata[nvm_pkg::bit_write_go]) begin
					if (unl == nvm_pkg::unl_armed && write_allow) begin
						if (!bus.wdata[nvm_pkg::bit_space]) begin
							next_write_go = 1'b1;
							next_count = nvm_pkg::ee_write_cycles;
							next_state = nvm_pkg::st_ee_write;
						end else if (fl_ok) begin
							next_write_go = 1'b1;
							next_count = 16'(nvm_pkg::flash_stall_slots);
							next_state = nvm_pkg::st_flash_write;
							next_stall = 1'b1;
						end
					end
				end else if (ctl_wr && bus.wdata[nvm_pkg::bit_read_go]) begin
					if (!bus.wdata[nvm_pkg::bit_space]) begin
						next_data_low = ee_mem[mem_addr_low[5:0]];
					end else begin
						next_read_go = 1'b1;
						next_count = 16'(nvm_pkg::flash_read_slots);
						next_state = nvm_pkg::st_flash_read;
					end
				end
			end
			nvm_pkg::st_flash_read: begin
				next_count = count - 16'h0001;
				if (count == 16'h0001) begin
					next_data_low = fl_mem[fl_addr][7:0];
					next_data_high = {2'b00, fl_mem[fl_addr][13:8]};
					next_read_go = 1'b0;
					next_state = nvm_pkg::st_idle;
				end
			end
			default: begin
				// write runs to completion regardless of allow
				next_count = count - 16'h0001;
				if (state == nvm_pkg::st_flash_write && count != 16'h0001)
					next_stall = 1'b1;
				if (count == 16'h0001) begin
					ee_commit = state == nvm_pkg::st_ee_write;
					fl_commit = state == nvm_pkg::st_flash_write;
					next_write_go = 1'b0;
					next_wcf = 1'b1;
					next_state = nvm_pkg::st_idle;
				end
			end
		endcase
		// warm reset aborts write, keeps addresses
		if (warm_reset) begin
			if (state == nvm_pkg::st_ee_write || state == nvm_pkg::st_flash_write)
				next_abort = 1'b1;
			ee_commit = 1'b0;
			fl_commit = 1'b0;
			next_write_go = 1'b0;
			next_read_go = 1'b0;
			next_allow = 1'b0;
			next_stall = 1'b0;
			next_unl = nvm_pkg::unl_none;
			next_state = nvm_pkg::st_idle;
		end
		next_rdata = 8'h00;
		if (bus.rd_en) begin
			if (bus.addr == nvm_pkg::reg_control)
				next_rdata = {next_space, 3'b000, next_abort, next_allow, next_write_go,
					next_read_go};
			else if (bus.addr == nvm_pkg::reg_data_low)
				next_rdata = next_data_low;
			else if (bus.addr == nvm_pkg::reg_data_high)
				next_rdata = next_data_high;
			else if (bus.addr == nvm_pkg::reg_addr_low)
				next_rdata = next_addr_low;
			else if (bus.addr == nvm_pkg::reg_addr_high)
				next_rdata = next_addr_high;
			else if (bus.addr == nvm_pkg::reg_flag)
				next_rdata = {7'h00, next_wcf};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mem_data_low <= 8'h00;
			mem_data_high <= 8'h00;
			mem_addr_low <= 8'h00;
			mem_addr_high <= 8'h00;
			space_select <= 1'b0;
			write_allow <= 1'b0;
			write_go <= 1'b0;
			read_go <= 1'b0;
			write_abort_flag <= 1'b0;
			wcf <= 1'b0;
			count <= 16'h0000;
			state <= nvm_pkg::st_idle;
			unl <= nvm_pkg::unl_none;
			stall <= 1'b0;
			rdata <= 8'h00;
		end else begin
			mem_data_low <= next_data_low;
			mem_data_high <= next_data_high;
			mem_addr_low <= next_addr_low;
			mem_addr_high <= next_addr_high;
			space_select <= next_space;
			write_allow <= next_allow;
			write_go <= next_write_go;
			read_go <= next_read_go;
			write_abort_flag <= next_abort;
			wcf <= next_wcf;
			count <= next_count;
			state <= next_state;
			unl <= next_unl;
			stall <= next_stall;
			rdata <= next_rdata;
		end
	end

	// Arrays are not reset: contents survive like nonvolatile cells
	always_ff @(posedge clk) begin
		if (ee_commit)
			ee_mem[mem_addr_low[5:0]] <= mem_data_low;
		if (fl_commit)
			fl_mem[fl_addr] <= {mem_data_high[5:0], mem_data_low};
	end

	assign bus.rdata = rdata;
	assign bus.stall = stall;
	assign bus.write_complete_flag = wcf;
endmodule

// [src/nvm_core_end.sv]
// Purpose: core-side sequencer issuing reads and writes of the memory controller
// Assumes: one user command at a time, accepted when idle
// Notes: issues the unlock pair back to back, with no other access between
module nvm_core_end (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// User commands
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic cmd_flash,
	input wire logic [10:0] cmd_addr,
	input wire logic [13:0] cmd_data,
	output logic cmd_idle,
	output logic done,
	output logic [13:0] rd_data,
	// Controller side
	nvm_if.core bus
);
	typedef enum logic [3:0] {c_idle, c_cap, c_adl, c_dh, c_dl, c_allow, c_u1, c_u2, c_go,
		c_wait, c_rdl, c_rdh, c_clr, c_flag} core_state_t;
	core_state_t st, next_st;
	logic wr, rd, next_wr, next_rd, w, f, next_w, next_f, next_done;
	logic [2:0] ad, next_ad;
	logic [7:0] wd, next_wd;
	logic [10:0] a, next_a;
	logic [13:0] d, next_d, next_rd_data;
	logic [2:0] gap, next_gap;
	logic idle_q, next_idle;
	logic polled, next_polled;

	always_comb begin
		next_st = st;
		next_wr = 1'b0;
		next_rd = 1'b0;
		next_ad = ad;
		next_wd = 8'h00;
		next_w = w;
		next_f = f;
		next_a = a;
		next_d = d;
		next_done = 1'b0;
		next_rd_data = rd_data;
		next_gap = gap;
		next_idle = 1'b0;
		next_polled = rd;
		case (st)
			c_idle: begin
				next_idle = !cmd_valid;
				if (cmd_valid) begin
					next_w = cmd_write;
					next_f = cmd_flash;
					next_a = cmd_addr;
					next_d = cmd_data;
					next_wr = 1'b1;
					next_ad = nvm_pkg::reg_addr_high;
					next_wd = {5'h00, cmd_addr[10:8]};
					next_st = c_adl;
				end
			end
			c_adl: begin
				next_wr = 1'b1;
				next_ad = nvm_pkg::reg_addr_low;
				next_wd = a[7:0];
				next_st = w ? c_dh : c_go;
			end
			c_dh: begin
				next_wr = 1'b1;
				next_ad = nvm_pkg::reg_data_high;
				next_wd = {2'b00, d[13:8]};
				next_st = c_dl;
			end
			c_dl: begin
				next_wr = 1'b1;
				next_ad = nvm_pkg::reg_data_low;
				next_wd = d[7:0];
				next_st = c_allow;
			end
			c_allow: begin
				next_wr = 1'b1;
				next_ad = nvm_pkg::reg_control;
				next_wd = {f, 7'h04};
				next_st = c_u1;
			end
			c_u1: begin
				next_wr = 1'b1;
				next_ad = nvm_pkg::reg_unlock;
				next_wd = nvm_pkg::unlock_first;
				next_st = c_u2;
			end
			c_u2: begin
				next_wr = 1'b1;
				next_ad = nvm_pkg::reg_unlock;
				next_wd = nvm_pkg::unlock_second;
				next_st = c_go;
			end
			c_go: begin
				next_wr = 1'b1;
				next_ad = nvm_pkg::reg_control;
				next_wd = w ? {f, 7'h06} : {f, 7'h01};
				next_gap = 3'h3;
				next_st = c_wait;
			end
			c_wait: begin
				next_gap = gap == 3'h0 ? 3'h0 : gap - 3'h1;
				if (gap == 3'h0) begin
					next_rd = 1'b1;
					next_ad = nvm_pkg::reg_control;
					// Answer belongs to the read one cycle back, not the one on the bus
					if (polled && !bus.stall && bus.rdata[1:0] == 2'b00)
						next_st = w ? c_clr : c_rdl;
				end
			end
			c_rdl: begin
				next_rd = 1'b1;
				next_ad = nvm_pkg::reg_data_low;
				next_st = c_rdh;
			end
			c_rdh: begin
				next_rd = 1'b1;
				next_ad = nvm_pkg::reg_data_high;
				next_st = c_cap;
			end
			c_cap: begin
				// Low byte answers the read issued two states back
				next_rd_data[7:0] = bus.rdata;
				next_st = c_clr;
			end
			c_clr: begin
				next_wr = 1'b1;
				next_ad = nvm_pkg::reg_control;
				next_wd = {f, 7'h00};
				if (!w)
					next_rd_data[13:8] = bus.rdata[5:0];
				next_done = !w;
				next_st = w ? c_flag : c_idle;
			end
			default: begin
				next_wr = 1'b1;
				next_ad = nvm_pkg::reg_flag;
				next_wd = 8'h00;
				next_done = 1'b1;
				next_st = c_idle;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st <= c_idle;
			wr <= 1'b0;
			rd <= 1'b0;
			ad <= 3'h0;
			wd <= 8'h00;
			w <= 1'b0;
			f <= 1'b0;
			a <= 11'h000;
			d <= 14'h0000;
			done <= 1'b0;
			rd_data <= 14'h0000;
			gap <= 3'h0;
			idle_q <= 1'b0;
			polled <= 1'b0;
		end else begin
			st <= next_st;
			wr <= next_wr;
			rd <= next_rd;
			ad <= next_ad;
			wd <= next_wd;
			w <= next_w;
			f <= next_f;
			a <= next_a;
			d <= next_d;
			done <= next_done;
			rd_data <= next_rd_data;
			gap <= next_gap;
			idle_q <= next_idle;
			polled <= next_polled;
		end
	end

	assign cmd_idle = idle_q;
	assign bus.wr_en = wr;
	assign bus.rd_en = rd;
	assign bus.addr = ad;
	assign bus.wdata = wd;
endmodule

// [sim/eeprom_flash_self_access_checker.sv]
// Purpose: concurrent checks on the core-to-controller register link
// Assumes: one clock; unlock progress is tracked from link writes alone
// Notes: warm reset is invisible here, so the watched pair keeps it low
module eeprom_flash_self_access_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Link signals
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic stall,
	input wire logic write_complete_flag
);
	logic [1:0] unl, next_unl;
	logic space, next_space, allow, next_allow, go_ok;
	logic [7:0] since_go, next_since_go;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	assign go_ok = wr_en && addr == nvm_pkg::reg_control && wdata[nvm_pkg::bit_write_go]
		&& unl == 2'h2 && allow;
	always_comb begin
		next_unl = unl;
		next_space = space;
		next_allow = allow;
		if (wr_en) begin
			next_unl = 2'h0;
			if (addr == nvm_pkg::reg_unlock && wdata == nvm_pkg::unlock_first)
				next_unl = 2'h1;
			if (addr == nvm_pkg::reg_unlock && wdata == nvm_pkg::unlock_second && unl == 2'h1)
				next_unl = 2'h2;
			if (addr == nvm_pkg::reg_control) begin
				next_space = wdata[nvm_pkg::bit_space];
				next_allow = wdata[nvm_pkg::bit_write_allow];
			end
		end
		// Saturates so a long idle span never wraps into a fake recent go
		next_since_go = go_ok ? 8'h00 : since_go + 8'(since_go != 8'hff);
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			unl <= 2'h0;
			space <= 1'b0;
			allow <= 1'b0;
			since_go <= 8'hff;
		end else begin
			unl <= next_unl;
			space <= next_space;
			allow <= next_allow;
			since_go <= next_since_go;
		end
	end
	go_needs_unlock_a: assert property (
		$rose(stall) |-> $past(go_ok) || $past(go_ok, 2)) else $error("stall without armed go");
	stall_two_slots_a: assert property (
		$rose(stall) |-> stall[*2] ##1 !stall) else $error("stall length wrong");
	stall_flash_only_a: assert property (
		$rose(stall) |-> space) else $error("stall with data space");
	flag_after_go_a: assert property (
		$rose(write_complete_flag) |-> since_go inside {[2:43]}) else $error("flag without go");
	flag_sw_clear_a: assert property (
		$fell(write_complete_flag) |-> $past(wr_en && addr == nvm_pkg::reg_flag && !wdata[0]))
		else $error("flag fell by itself");
	allow_kept_a: assert property (
		rd_en && addr == nvm_pkg::reg_control |=> rdata[6:4] == 3'h0
		&& rdata[nvm_pkg::bit_write_allow] == allow) else $error("allow bit changed");
	high_data_a: assert property (
		rd_en && addr == nvm_pkg::reg_data_high |=> rdata[7:6] == 2'h0)
		else $error("high data upper bits set");
	go_cleared_a: assert property (
		rd_en && addr == nvm_pkg::reg_control && since_go >= 8'(nvm_pkg::ee_write_cycles)
		|=> !rdata[1])
		else $error("write go stuck");
	cover property ($rose(stall));
	cover property ($rose(write_complete_flag) && !space);
	cover property (go_ok && space);
endmodule

// [sim/eeprom_flash_self_access_tb.sv]
// Purpose: self-checking bench, core end against controller plus a raw link
// Assumes: one clock edge per instruction cycle
// Notes: the raw link lets the bench break the unlock and allow rules
module eeprom_flash_self_access_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, warm_reset, permit, partial, cmd_valid, cmd_write, cmd_flash;
	logic cmd_idle, done;
	logic [10:0] limit, cmd_addr;
	logic [13:0] cmd_data, rd_data, q;
	logic [7:0] v, a, d;
	int err_total, checked, rs;
	logic [10:0] bad [4][5];
	logic [40:0] row [4];
	nvm_if link (.clk(clk));
	nvm_if link2 (.clk(clk));
	nvm_ctrl nvm_ctrl_i (.clk(clk), .rst_b(rst_b), .warm_reset(1'b0),
		.flash_write_permit(permit), .code_protect_partial(partial), .protect_limit(limit),
		.bus(link));
	nvm_ctrl nvm_ctrl_i2 (.clk(clk), .rst_b(rst_b), .warm_reset(warm_reset),
		.flash_write_permit(permit), .code_protect_partial(partial), .protect_limit(limit),
		.bus(link2));
	nvm_core_end nvm_core_end_i (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_flash(cmd_flash), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .cmd_idle(cmd_idle), .done(done), .rd_data(rd_data), .bus(link));
	eeprom_flash_self_access_checker chk_i (.clk(clk), .rst_b(rst_b), .wr_en(link.wr_en),
		.rd_en(link.rd_en), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
		.stall(link.stall), .write_complete_flag(link.write_complete_flag));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task finish_test;
		if (err_total == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task hang;
		err_total++;
		finish_test();
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [13:0] word_of(input logic [7:0] hi, input logic [7:0] lo);
		return {hi[5:0], lo};
	endfunction
	task cmd(input logic w, input logic f, input logic [10:0] ad, input logic [13:0] dd);
		int n;
		n = 0;
		while (cmd_idle !== 1'b1) begin
			@(posedge clk);
			n++;
			if (n > 300) hang();
		end
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_flash <= f;
		cmd_addr <= ad;
		cmd_data <= dd;
		@(posedge clk);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (n > 300) hang();
		end while (done !== 1'b1);
		q = rd_data;
	endtask
	// Strobe stays up between back-to-back writes so the unlock pair is consecutive
	task wr2(input logic [10:0] ad_d);
		link2.wr_en <= 1'b1;
		link2.rd_en <= 1'b0;
		link2.addr <= ad_d[10:8];
		link2.wdata <= ad_d[7:0];
		@(posedge clk);
	endtask
	task rd2(input logic [2:0] ad);
		link2.wr_en <= 1'b0;
		link2.rd_en <= 1'b1;
		link2.addr <= ad;
		@(posedge clk);
		link2.rd_en <= 1'b0;
		@(posedge clk);
		v = link2.rdata;
	endtask
	task go2;
		wr2(11'h155);
		wr2(11'h1aa);
		wr2(11'h006);
		rd2(nvm_pkg::reg_control);
	endtask
	initial begin
		rst_b = 1'b0;
		warm_reset = 1'b0;
		permit = 1'b1;
		partial = 1'b0;
		limit = 11'h400;
		{cmd_valid, cmd_write, cmd_flash, cmd_addr, cmd_data} = '0;
		{link2.wr_en, link2.rd_en, link2.addr, link2.wdata} = '0;
		err_total = 0;
		checked = 0;
		bad = '{'{11'h000, 11'h000, 11'h155, 11'h1aa, 11'h002},
			'{11'h000, 11'h000, 11'h155, 11'h1aa, 11'h006},
			'{11'h004, 11'h155, 11'h25a, 11'h1aa, 11'h006},
			'{11'h004, 11'h004, 11'h1aa, 11'h155, 11'h006}};
		row = '{{11'h7ff, 14'h3fff, 2'b10, 14'h3fff}, {11'h7ff, 14'h0000, 2'b11, 14'h3fff},
			{11'h3ff, 14'h1234, 2'b11, 14'h1234}, {11'h3ff, 14'h0abc, 2'b00, 14'h1234}};
		rs = $urandom(32'h27f7);
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			a = 8'($urandom);
			d = 8'($urandom);
			cmd(1'b1, 1'b0, {5'h0, a[5:0]}, {6'h0, d});
			cmd(1'b0, 1'b0, {5'h0, a[5:0]}, 14'h0);
			chk(q[7:0], d);
			cmd(1'b1, 1'b1, {5'h0, a[5:0]}, word_of(a, ~d));
			cmd(1'b0, 1'b1, {5'h0, a[5:0]}, 14'h0);
			chk(q, word_of(a, ~d));
			cmd(1'b0, 1'b0, {5'h0, a[5:0]}, 14'h0);
			chk(q[7:0], d);
		end
		for (int i = 0; i < 4; i++) begin
			{permit, partial} <= row[i][15:14];
			cmd(1'b1, 1'b1, row[i][40:30], row[i][29:16]);
			cmd(1'b0, 1'b1, row[i][40:30], 14'h0);
			chk(q, row[i][13:0]);
		end
		for (int i = 0; i < 4; i++) begin
			for (int k = 0; k < 5; k++) wr2(bad[i][k]);
			rd2(nvm_pkg::reg_control);
			chk(v[1], 1'b0);
		end
		repeat (45) @(posedge clk);
		rd2(nvm_pkg::reg_flag);
		chk(v[0], 1'b0);
		wr2({nvm_pkg::reg_addr_low, a});
		wr2({nvm_pkg::reg_data_low, d});
		wr2(11'h004);
		go2();
		// Dropping allow mid-write must neither stop it nor clear write-go
		wr2(11'h000);
		rd2(nvm_pkg::reg_control);
		chk(v[2:1], 2'b01);
		for (int n = 0; n < 60 && v[0] !== 1'b1; n++) rd2(nvm_pkg::reg_flag);
		chk(v[0], 1'b1);
		rd2(nvm_pkg::reg_control);
		chk(v[1], 1'b0);
		wr2({nvm_pkg::reg_flag, 8'h00});
		rd2(nvm_pkg::reg_flag);
		chk(v[0], 1'b0);
		wr2(11'h001);
		rd2(nvm_pkg::reg_data_low);
		chk(v, d);
		wr2({nvm_pkg::reg_addr_low, ~a});
		rd2(nvm_pkg::reg_data_low);
		chk(v, d);
		wr2({nvm_pkg::reg_addr_low, a});
		wr2(11'h004);
		go2();
		repeat (5) @(posedge clk);
		warm_reset <= 1'b1;
		@(posedge clk);
		warm_reset <= 1'b0;
		rd2(nvm_pkg::reg_control);
		chk(v[3:1], 3'b100);
		rd2(nvm_pkg::reg_addr_low);
		chk(v, a);
		finish_test();
	end
endmodule
